// ---- design/rtc_consts.vh ----
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// ---------------------------------------------------------------
// Internal register addresses
// ---------------------------------------------------------------
`define RTC_ADDR_DAY        4'h4
`define RTC_ADDR_MONTH      4'h5
`define RTC_ADDR_YEAR       4'h6
`define RTC_ADDR_TRIM       4'h7
`define RTC_ADDR_A_MIN      4'h8
`define RTC_ADDR_A_HOUR     4'h9
`define RTC_ADDR_B_MIN      4'hb
`define RTC_ADDR_B_HOUR     4'hc

// ---------------------------------------------------------------
// Field positions of the trimming register
// ---------------------------------------------------------------
`define RTC_TRIM_XSEL_BIT   7
`define RTC_TRIM_DIR_BIT    6
`define RTC_TRIM_MAG_HI     5
`define RTC_TRIM_MAG_LO     0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RTC_TRIM_RESET      8'h00
`define RTC_DAY_RESET       6'h01
`define RTC_MONTH_RESET     5'h01
`define RTC_YEAR_RESET      8'h00
`define RTC_MIN_RESET       7'h00
`define RTC_HOUR_RESET      6'h00

// ---------------------------------------------------------------
// Oscillator pulses per nominal second, and corrected seconds
// ---------------------------------------------------------------
`define RTC_NOM_32768       16'h8000
`define RTC_NOM_32000       16'h7d00
`define RTC_SEC_00          7'h00
`define RTC_SEC_20          7'h20
`define RTC_SEC_40          7'h40

`endif

// ---- design/rtc_trim_divider.v ----
`timescale 1ns/100ps
`include "rtc_consts.vh"

// Counts oscillator pulses into one-second ticks with trimming
module rtc_trim_divider (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Oscillator pulse, one cycle per crystal period
  input  wire       osc_tick,
  // Trimming control
  input  wire [7:0] trim_value,
  input  wire [6:0] cur_sec,
  // One-second tick to the seconds counter
  output reg        second_tick
);

  // ---------------------------------------------------------------
  // Period of the second being counted
  // ---------------------------------------------------------------
  wire        crystal_select = trim_value[`RTC_TRIM_XSEL_BIT];
  wire        trim_direction = trim_value[`RTC_TRIM_DIR_BIT];
  wire [5:0]  trim_magnitude = trim_value[`RTC_TRIM_MAG_HI:`RTC_TRIM_MAG_LO];
  wire [15:0] nominal;        // Pulses per untrimmed second
  wire        trim_enable;    // Nonzero correction written
  wire        corrected_sec;  // This second is a corrected one
  wire [6:0]  up_count;       // (mag - 1) * 2
  wire [6:0]  down_count;     // (~mag + 1) * 2, held in 7 bits
  reg  [15:0] period;         // Pulses in the current second
  reg  [15:0] count;          // Pulses counted so far

  assign nominal = crystal_select ? `RTC_NOM_32000 : `RTC_NOM_32768;
  assign trim_enable = |trim_magnitude[5:1];
  assign corrected_sec = (cur_sec == `RTC_SEC_00) || (cur_sec == `RTC_SEC_20) ||
                         (cur_sec == `RTC_SEC_40);
  assign up_count = {trim_magnitude - 6'h01, 1'b0};
  assign down_count = {(~trim_magnitude) + 6'h01, 1'b0};

  // A magnitude of zero cannot occur here: bits 5..1 would be all zero,
  // so a down step of 128 pulses never wraps the 7-bit field
  always @* begin
    if (trim_enable && corrected_sec && !trim_direction) begin
      period = nominal + {9'h000, up_count};
    end else if (trim_enable && corrected_sec) begin
      period = nominal - {9'h000, down_count};
    end else begin
      period = nominal;
    end
  end

  // ---------------------------------------------------------------
  // Pulse counter; >= guards against a period shrinking mid-second
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count       <= 16'h0000;
      second_tick <= 1'b0;
    end else begin
      second_tick <= 1'b0;
      if (osc_tick) begin
        if (count >= period - 16'h0001) begin
          count       <= 16'h0000;
          second_tick <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end

endmodule // rtc_trim_divider

// ---- design/rtc_alarm_match.v ----
`timescale 1ns/100ps

// One alarm: minute and hour compare with weekday mask
module rtc_alarm_match (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Alarm set-up
  input  wire       alarm_enable,
  input  wire [6:0] alarm_weekday_mask,
  input  wire [6:0] cmp_minute,
  input  wire [5:0] cmp_hour,
  // Running time
  input  wire [6:0] cur_min,
  input  wire [5:0] cur_hour,
  input  wire [2:0] cur_weekday,
  input  wire       minute_rollover,
  // Flag clear from the control side, one-cycle pulse
  input  wire       flag_clear,
  // Sticky match flag
  output reg        match_flag
);

  // ---------------------------------------------------------------
  // Match detection, sampled only at minute rollover
  // ---------------------------------------------------------------
  wire day_ok;  // Weekday selected by the mask
  wire hit;     // Full match this minute

  // Weekday value 7 is illegal and selects nothing
  assign day_ok = (cur_weekday != 3'h7) && alarm_weekday_mask[cur_weekday];
  // Raw compare serves both 12- and 24-hour codings
  assign hit = minute_rollover && alarm_enable && day_ok &&
               (cur_min == cmp_minute) && (cur_hour == cmp_hour);

  // Set wins over a clear in the same cycle; disabled alarm reads zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      match_flag <= 1'b0;
    end else if (!alarm_enable) begin
      match_flag <= 1'b0;
    end else if (hit) begin
      match_flag <= 1'b1;
    end else if (flag_clear) begin
      match_flag <= 1'b0;
    end
  end

endmodule // rtc_alarm_match

// ---- design/rtc_calendar_trim_alarm.v ----
`timescale 1ns/100ps
`include "rtc_consts.vh"

module rtc_calendar_trim_alarm (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,

  // Internal register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr_en,
  output reg  [7:0] reg_rdata,

  // Oscillator and halt sensing, asynchronous
  input  wire       osc_in,
  input  wire       oscillator_halt_flag,

  // Running time from the seconds to hours counters
  input  wire [6:0] cur_sec,
  input  wire [6:0] cur_min,
  input  wire [5:0] cur_hour,
  input  wire [2:0] cur_weekday,
  input  wire       minute_rollover,
  input  wire       day_carry,

  // Alarm control
  input  wire       first_alarm_enable,
  input  wire       second_alarm_enable,
  input  wire [6:0] first_alarm_weekday_mask,
  input  wire [6:0] second_alarm_weekday_mask,
  input  wire       first_alarm_flag_clear,
  input  wire       second_alarm_flag_clear,

  // Outputs
  output wire       second_tick,
  output wire       osc_clk_out,
  output wire       first_alarm_match_flag,
  output wire       second_alarm_match_flag
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  reg  [5:0] calendar_day;         // BCD day, 01..31
  reg  [4:0] calendar_month;       // BCD month, 01..12
  reg  [7:0] calendar_year;        // BCD year, 00..99
  reg  [7:0] crystal_trim_control; // Crystal select, direction, magnitude
  reg  [6:0] first_alarm_minute;   // BCD minute compare
  reg  [5:0] first_alarm_hour;     // BCD hour compare, bit 5 twenties/PM
  reg  [6:0] second_alarm_minute;  // BCD minute compare
  reg  [5:0] second_alarm_hour;    // BCD hour compare, bit 5 twenties/PM

  // Synchronisers and edge detect
  reg        osc_meta;             // First stage, read only by osc_sync
  reg        osc_sync;             // Second stage
  reg        osc_prev;             // Delayed copy for edge detection
  reg        halt_meta;            // First stage, read only by halt_sync
  reg        halt_sync;            // Halt flag in the clock domain
  wire       osc_tick;             // One cycle per oscillator period

  // Calendar next values
  reg  [5:0] next_day;
  reg  [4:0] next_month;
  reg  [7:0] next_year;
  reg  [7:0] next_rdata;
  wire       leap_year;            // Current year has Feb 29
  wire [5:0] last_day;             // Last BCD day of current month
  wire [7:0] day_inc;              // Day plus one, wide BCD result
  wire [7:0] month_inc;            // Month plus one, wide BCD result

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Increment a two-digit BCD value, 99 wrapping to 00
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] != 4'h9) begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end else if (v[7:4] != 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = 8'h00;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Both inputs come from outside the clock domain
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_meta  <= 1'b0;
      osc_sync  <= 1'b0;
      osc_prev  <= 1'b0;
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end else begin
      osc_meta  <= osc_in;
      osc_sync  <= osc_meta;
      osc_prev  <= osc_sync;
      halt_meta <= oscillator_halt_flag;
      halt_sync <= halt_meta;
    end
  end

  // Rising edge of the crystal, seen two cycles late
  assign osc_tick = osc_sync & ~osc_prev;

  // Free-running crystal clock; the trim logic never touches it
  assign osc_clk_out = osc_sync;

  // ---------------------------------------------------------------
  // Leap year and month length
  // ---------------------------------------------------------------
  // Divisible by four: even tens with units 0/4/8, odd tens with 2/6
  assign leap_year = calendar_year[4] ?
                     (calendar_year[3:0] == 4'h2 || calendar_year[3:0] == 4'h6) :
                     (calendar_year[3:0] == 4'h0 || calendar_year[3:0] == 4'h4 ||
                      calendar_year[3:0] == 4'h8);

  // Month length; out-of-range months fall to 31 days
  assign last_day = (calendar_month == 5'h02) ? (leap_year ? 6'h29 : 6'h28) :
                    (calendar_month == 5'h04 || calendar_month == 5'h06 ||
                     calendar_month == 5'h09 || calendar_month == 5'h11) ?
                    6'h30 : 6'h31;

  // Incremented digits; upper bits stay zero for legal contents
  assign day_inc   = bcd_inc({2'h0, calendar_day});
  assign month_inc = bcd_inc({3'h0, calendar_month});

  // ---------------------------------------------------------------
  // Calendar advance on the day carry
  // ---------------------------------------------------------------
  // Illegal BCD contents give garbage carries; keeping them legal
  // is left to the host, which saves range checks here
  always @* begin
    next_day   = calendar_day;
    next_month = calendar_month;
    next_year  = calendar_year;
    if (day_carry) begin
      if (calendar_day >= last_day) begin
        next_day = 6'h01;
        if (calendar_month >= 5'h12) begin
          next_month = 5'h01;
          next_year  = bcd_inc(calendar_year);
        end else begin
          next_month = month_inc[4:0];
        end
      end else begin
        next_day = day_inc[5:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // A host write beats the carry into the same register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      calendar_day         <= `RTC_DAY_RESET;
      calendar_month       <= `RTC_MONTH_RESET;
      calendar_year        <= `RTC_YEAR_RESET;
      crystal_trim_control <= `RTC_TRIM_RESET;
      first_alarm_minute   <= `RTC_MIN_RESET;
      first_alarm_hour     <= `RTC_HOUR_RESET;
      second_alarm_minute  <= `RTC_MIN_RESET;
      second_alarm_hour    <= `RTC_HOUR_RESET;
    end else begin
      // Calendar counts, overridden below by a write
      calendar_day   <= next_day;
      calendar_month <= next_month;
      calendar_year  <= next_year;
      if (reg_wr_en) begin
        case (reg_addr)
          `RTC_ADDR_DAY: begin
            calendar_day <= reg_wdata[5:0];
          end
          `RTC_ADDR_MONTH: begin
            calendar_month <= reg_wdata[4:0];
          end
          `RTC_ADDR_YEAR: begin
            calendar_year <= reg_wdata;
          end
          `RTC_ADDR_TRIM: begin
            crystal_trim_control <= reg_wdata;
          end
          `RTC_ADDR_A_MIN: begin
            first_alarm_minute <= reg_wdata[6:0];
          end
          `RTC_ADDR_A_HOUR: begin
            first_alarm_hour <= reg_wdata[5:0];
          end
          `RTC_ADDR_B_MIN: begin
            second_alarm_minute <= reg_wdata[6:0];
          end
          `RTC_ADDR_B_HOUR: begin
            second_alarm_hour <= reg_wdata[5:0];
          end
          default: begin
            // Other addresses belong to blocks outside this one
          end
        endcase
      end
      // Halt holds the trim register at its default, over any write
      if (halt_sync) begin
        crystal_trim_control <= `RTC_TRIM_RESET;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Digit bits are not cleared on halt: their stale contents are
  // what "undefined" means here, while unused bits stay zero
  always @* begin
    case (reg_addr)
      `RTC_ADDR_DAY: begin
        next_rdata = {2'h0, calendar_day};
      end
      `RTC_ADDR_MONTH: begin
        next_rdata = {3'h0, calendar_month};
      end
      `RTC_ADDR_YEAR: begin
        next_rdata = calendar_year;
      end
      `RTC_ADDR_TRIM: begin
        next_rdata = crystal_trim_control;
      end
      `RTC_ADDR_A_MIN: begin
        next_rdata = {1'b0, first_alarm_minute};
      end
      `RTC_ADDR_A_HOUR: begin
        next_rdata = {2'h0, first_alarm_hour};
      end
      `RTC_ADDR_B_MIN: begin
        next_rdata = {1'b0, second_alarm_minute};
      end
      `RTC_ADDR_B_HOUR: begin
        next_rdata = {2'h0, second_alarm_hour};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data is registered: one cycle after the address
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Second divider with trimming
  // ---------------------------------------------------------------
  rtc_trim_divider u_divider (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .osc_tick    (osc_tick),
    .trim_value  (crystal_trim_control),
    .cur_sec     (cur_sec),
    .second_tick (second_tick)
  );

  // ---------------------------------------------------------------
  // Two alarms, identical apart from their registers
  // ---------------------------------------------------------------
  rtc_alarm_match u_first_alarm (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .alarm_enable       (first_alarm_enable),
    .alarm_weekday_mask (first_alarm_weekday_mask),
    .cmp_minute         (first_alarm_minute),
    .cmp_hour           (first_alarm_hour),
    .cur_min            (cur_min),
    .cur_hour           (cur_hour),
    .cur_weekday        (cur_weekday),
    .minute_rollover    (minute_rollover),
    .flag_clear         (first_alarm_flag_clear),
    .match_flag         (first_alarm_match_flag)
  );

  rtc_alarm_match u_second_alarm (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .alarm_enable       (second_alarm_enable),
    .alarm_weekday_mask (second_alarm_weekday_mask),
    .cmp_minute         (second_alarm_minute),
    .cmp_hour           (second_alarm_hour),
    .cur_min            (cur_min),
    .cur_hour           (cur_hour),
    .cur_weekday        (cur_weekday),
    .minute_rollover    (minute_rollover),
    .flag_clear         (second_alarm_flag_clear),
    .match_flag         (second_alarm_match_flag)
  );

endmodule // rtc_calendar_trim_alarm

// ---- dv/rtc_chk.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the calendar, trim and alarm slice
// ----------------------------------------
module rtc_chk (
  // Clock and reset
  input wire       sys_clk,
  input wire       rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr_en,
  input wire [7:0] reg_rdata,
  // Oscillator, halt and alarm set-up
  input wire       osc_in,
  input wire       oscillator_halt_flag,
  input wire       minute_rollover,
  input wire       first_alarm_enable,
  input wire       second_alarm_enable,
  input wire [6:0] first_alarm_weekday_mask,
  input wire [6:0] second_alarm_weekday_mask,
  // Outputs
  input wire       second_tick,
  input wire       osc_clk_out,
  input wire       first_alarm_match_flag,
  input wire       second_alarm_match_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_day; reg_addr == 4'h4 |=> reg_rdata[7:6] == 2'b00; endproperty
  a_day: assert property (p_day) else $error("day high bits set");
  property p_month; reg_addr == 4'h5 |=> reg_rdata[7:5] == 3'b000; endproperty
  a_month: assert property (p_month) else $error("month high bits set");
  property p_amin; (reg_addr == 4'h8 || reg_addr == 4'hb) |=> !reg_rdata[7]; endproperty
  a_amin: assert property (p_amin) else $error("alarm minute bit 7 set");
  property p_ahour; (reg_addr == 4'h9 || reg_addr == 4'hc) |=> reg_rdata[7:6] == 2'b00; endproperty
  a_ahour: assert property (p_ahour) else $error("alarm hour high bits set");
  // Holes in the map read as zero, so stale bus data never leaks out
  property p_hole; (reg_addr < 4'h4 || reg_addr == 4'ha || reg_addr > 4'hc) |=> reg_rdata == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  // Halt must be low long enough to clear its two-flop synchroniser
  property p_trim_rw; (!oscillator_halt_flag[*5] ##0 (reg_wr_en && reg_addr == 4'h7)) ##1
    (reg_addr == 4'h7 && !reg_wr_en && !oscillator_halt_flag) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_trim_rw: assert property (p_trim_rw) else $error("trim read back wrong");
  property p_halt; oscillator_halt_flag[*4] ##0 reg_addr == 4'h7 |=> reg_rdata == 8'h00; endproperty
  a_halt: assert property (p_halt) else $error("trim not cleared by halt");
  property p_dis; !first_alarm_enable[*2] |-> !first_alarm_match_flag; endproperty
  a_dis: assert property (p_dis) else $error("disabled alarm flagged");
  property p_rise_a; $rose(first_alarm_match_flag) |->
    $past(minute_rollover && first_alarm_enable && (first_alarm_weekday_mask != 7'h00)); endproperty
  a_rise_a: assert property (p_rise_a) else $error("first flag without cause");
  property p_rise_b; $rose(second_alarm_match_flag) |->
    $past(minute_rollover && second_alarm_enable && (second_alarm_weekday_mask != 7'h00)); endproperty
  a_rise_b: assert property (p_rise_b) else $error("second flag without cause");
  property p_osc; osc_clk_out == $past(osc_in, 2); endproperty
  a_osc: assert property (p_osc) else $error("clock output altered");
  property p_tick; second_tick |=> !second_tick; endproperty
  a_tick: assert property (p_tick) else $error("second tick too long");
  c_alarm: cover property ($rose(first_alarm_match_flag));
  c_tick: cover property (second_tick);
  c_halt: cover property (oscillator_halt_flag ##1 reg_addr == 4'h7);
endmodule // rtc_chk

bind rtc_calendar_trim_alarm rtc_chk u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr_en,
  .reg_rdata, .osc_in, .oscillator_halt_flag, .minute_rollover, .first_alarm_enable,
  .second_alarm_enable, .first_alarm_weekday_mask, .second_alarm_weekday_mask, .second_tick,
  .osc_clk_out, .first_alarm_match_flag, .second_alarm_match_flag);

// ---- dv/rtc_host_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module rtc_host_model (
  // Clock
  input wire       sys_clk,
  // Register port toward the device
  output reg [3:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg       reg_wr_en,
  input wire [7:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
  end
  // Single byte write; strobe lasts one cycle, then data is scrambled
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  // Read data is registered, so wait two edges with the address held
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      @(posedge sys_clk);
      @(posedge sys_clk);
      d = reg_rdata;
    end
  endtask
endmodule // rtc_host_model

// ---- dv/tb_rtc_calendar_trim_alarm.sv ----
`timescale 1ns/100ps
module tb_rtc_calendar_trim_alarm;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  reg         sys_clk, rst, osc_in, halt, roll, carry, en_a, en_b, clr_a, clr_b;
  reg  [6:0]  cur_sec, cur_min, mask_a, mask_b;
  reg  [5:0]  cur_hour;
  reg  [2:0]  cur_wd;
  wire [3:0]  reg_addr;
  wire [7:0]  reg_wdata, reg_rdata;
  wire        reg_wr_en, second_tick, osc_clk_out, flag_a, flag_b;
  integer     n_fail, n_tests, n;
  reg  [7:0]  rv;

  rtc_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_en(reg_wr_en), .reg_rdata(reg_rdata));
  rtc_calendar_trim_alarm dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rdata(reg_rdata), .osc_in(osc_in),
    .oscillator_halt_flag(halt), .cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour),
    .cur_weekday(cur_wd), .minute_rollover(roll), .day_carry(carry),
    .first_alarm_enable(en_a), .second_alarm_enable(en_b), .first_alarm_weekday_mask(mask_a),
    .second_alarm_weekday_mask(mask_b), .first_alarm_flag_clear(clr_a),
    .second_alarm_flag_clear(clr_b), .second_tick(second_tick), .osc_clk_out(osc_clk_out),
    .first_alarm_match_flag(flag_a), .second_alarm_match_flag(flag_b));

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task check8(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task check1(input got, input exp);
    begin
      check8({7'h00, got}, {7'h00, exp});
    end
  endtask
  task rd_chk(input [3:0] a, input [7:0] exp);
    begin
      host.rd(a, rv);
      check8(rv, exp);
    end
  endtask
  task wr_rd(input [3:0] a, input [7:0] d, input [7:0] exp);
    begin
      host.wr(a, d);
      rd_chk(a, exp);
    end
  endtask
  // One-cycle pulses; flag sampled once the pulse has been taken
  task pulse_roll;
    begin
      @(posedge sys_clk) roll <= 1'b1;
      @(posedge sys_clk) roll <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task pulse_carry;
    begin
      @(posedge sys_clk) carry <= 1'b1;
      @(posedge sys_clk) carry <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_masks;
    begin
      rd_chk(4'h7, 8'h00);
      wr_rd(4'h4, 8'hff, 8'h3f);
      wr_rd(4'h5, 8'hff, 8'h1f);
      wr_rd(4'h6, 8'hff, 8'hff);
      wr_rd(4'h7, 8'hff, 8'hff);
      wr_rd(4'h8, 8'hff, 8'h7f);
      wr_rd(4'hb, 8'hff, 8'h7f);
      wr_rd(4'h9, 8'hff, 8'h3f);
      wr_rd(4'hc, 8'hff, 8'h3f);
      wr_rd(4'ha, 8'hff, 8'h00);
      wr_rd(4'h3, 8'hff, 8'h00);
    end
  endtask
  task t_halt;
    begin
      @(posedge sys_clk) halt <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rd_chk(4'h7, 8'h00);
      wr_rd(4'h7, 8'h55, 8'h00);
      rd_chk(4'h4, 8'h3f);
      @(posedge sys_clk) halt <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
  endtask
  task t_calendar;
    begin
      host.wr(4'h6, 8'h04);
      host.wr(4'h5, 8'h02);
      host.wr(4'h4, 8'h28);
      pulse_carry;
      rd_chk(4'h4, 8'h29);
      host.wr(4'h6, 8'h01);
      host.wr(4'h4, 8'h28);
      pulse_carry;
      rd_chk(4'h4, 8'h01);
      rd_chk(4'h5, 8'h03);
      host.wr(4'h6, 8'h99);
      host.wr(4'h5, 8'h12);
      host.wr(4'h4, 8'h31);
      pulse_carry;
      rd_chk(4'h6, 8'h00);
    end
  endtask
  task t_alarm;
    begin
      host.wr(4'h8, 8'h30);
      host.wr(4'h9, 8'h32);
      host.wr(4'hb, 8'h59);
      host.wr(4'hc, 8'h23);
      cur_min <= 7'h30;
      cur_hour <= 6'h32;
      pulse_roll;
      check1(flag_a, 1'b1);
      check1(flag_b, 1'b0);
      @(posedge sys_clk) clr_a <= 1'b1;
      @(posedge sys_clk) clr_a <= 1'b0;
      @(posedge sys_clk);
      check1(flag_a, 1'b0);
      cur_hour <= 6'h12;
      pulse_roll;
      check1(flag_a, 1'b0);
      cur_hour <= 6'h32;
      mask_a <= 7'h00;
      pulse_roll;
      check1(flag_a, 1'b0);
      mask_a <= 7'h7f;
      en_a <= 1'b0;
      pulse_roll;
      check1(flag_a, 1'b0);
      en_a <= 1'b1;
      cur_min <= 7'h59;
      cur_hour <= 6'h23;
      pulse_roll;
      check1(flag_b, 1'b1);
      check1(flag_a, 1'b0);
      // Match and clear in one cycle: the match wins
      @(posedge sys_clk) {roll, clr_b} <= 2'b11;
      @(posedge sys_clk) {roll, clr_b} <= 2'b00;
      @(posedge sys_clk);
      check1(flag_b, 1'b1);
      @(posedge sys_clk) clr_b <= 1'b1;
      @(posedge sys_clk) clr_b <= 1'b0;
      @(posedge sys_clk);
      check1(flag_b, 1'b0);
    end
  endtask
  // 32000-pulse crystal shortened by 4 on a corrected second gives 31996
  task t_trim;
    begin
      host.wr(4'h7, 8'hfe);
      n = 0;
      while (!second_tick && n < 40000) begin
        @(posedge sys_clk);
        if (!osc_in) n = n + 1;
        osc_in <= ~osc_in;
      end
      check1(n >= 31996 && n <= 31999, 1'b1);
    end
  endtask

  // ----------------------------------------
  // Clock, sequence, watchdog and verdict
  // ----------------------------------------
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #4_500_000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial begin
    n_fail = 0;
    n_tests = 0;
    {rst, osc_in, halt, roll, carry, clr_a, clr_b} = 7'h01 << 6;
    {en_a, en_b} = 2'b11;
    cur_sec = 7'h00;
    cur_min = 7'h00;
    cur_hour = 6'h00;
    cur_wd = 3'h1;
    mask_a = 7'h7f;
    mask_b = 7'h02;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_masks;
    t_halt;
    t_calendar;
    t_alarm;
    t_trim;
    report_and_stop;
  end
endmodule // tb_rtc_calendar_trim_alarm
